// ===== src/a5bw_pkg.sv
// Package of constants, types and timing decode for the area 5 wait controller
package a5bw_pkg;

    // ****************************************
    // Register map and field layout
    // ****************************************
    localparam logic [11:0] A5BW_CTRL_OFS = 12'h000;
    localparam int A5BW_WW_MSB = 18;
    localparam int A5BW_WW_LSB = 16;
    localparam int A5BW_SW_MSB = 12;
    localparam int A5BW_SW_LSB = 11;
    localparam int A5BW_RW_MSB = 10;
    localparam int A5BW_RW_LSB = 7;
    localparam int A5BW_RSV_LSB = 19;
    localparam logic [31:0] A5BW_CTRL_RST = 32'h0000_0500;
    localparam logic [31:0] A5BW_CTRL_WMASK = 32'h0007_1f80;
    localparam logic [1:0] A5BW_RESP_OKAY = 2'h0;
    localparam logic [1:0] A5BW_RESP_DECERR = 2'h3;

    // ****************************************
    // Access sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        A5BW_IDLE = 4'h1,
        A5BW_SETUP = 4'h2,
        A5BW_STROBE = 4'h4,
        A5BW_HOLD = 4'h8
    } a5bw_fsm_t;

    // Read wait code to cycles; prohibited codes fall back to the longest wait
    function automatic logic [4:0] a5bw_rd_wait(input logic [3:0] code);
        logic [4:0] w;
        w = 5'h18;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: w = {1'b0, code};
            4'h7: w = 5'h08;
            4'h8: w = 5'h0a;
            4'h9: w = 5'h0c;
            4'ha: w = 5'h0e;
            4'hb: w = 5'h12;
            default: w = 5'h18;
        endcase
        return w;
    endfunction : a5bw_rd_wait

    // Wait cycles of one access from the control word
    function automatic logic [4:0] a5bw_phase_wait(input logic wr, input logic [31:0] c);
        logic [2:0] ww;
        ww = c[A5BW_WW_MSB:A5BW_WW_LSB];
        if (wr && ww != 3'h0) begin
            return {2'h0, ww - 3'h1};
        end
        return a5bw_rd_wait(c[A5BW_RW_MSB:A5BW_RW_LSB]);
    endfunction : a5bw_phase_wait

endpackage : a5bw_pkg

// ===== src/a5bw_strobe_if.sv
// Interface carrying strobe requests to the opposite-edge retimer
`timescale 1ns/1ps
interface a5bw_strobe_if;
    logic rd_req;
    logic wr_req;
    logic [3:0] be_req;
    logic rd_n;
    logic we_n;
    logic [3:0] be_n;
    modport ctrl (output rd_req, output wr_req, output be_req,
                  input rd_n, input we_n, input be_n);
    modport retime (input rd_req, input wr_req, input be_req,
                    output rd_n, output we_n, output be_n);
endinterface : a5bw_strobe_if

// ===== src/a5bw_strobe_retime.sv
// Falling-edge retimer that places strobes half a cycle after the rising-edge request
`timescale 1ns/1ps
module a5bw_strobe_retime
    import a5bw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    a5bw_strobe_if.retime stb
);

    typedef struct packed {
        logic rd_n;
        logic we_n;
        logic [3:0] be_n;
    } a5bw_rt_t;

    a5bw_rt_t state_ff;
    a5bw_rt_t nxt_state;

    // Strobes follow the requests, inverted, on the falling edge
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rd_n = ~stb.rd_req;  // [RQ8]
        nxt_state.we_n = ~stb.wr_req;  // [RQ8]
        nxt_state.be_n = ~stb.be_req;
    end

    // Falling-edge registers with synchronous reset
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            state_ff <= '{rd_n: 1'b1, we_n: 1'b1, be_n: 4'hf};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign stb.rd_n = state_ff.rd_n;
    assign stb.we_n = state_ff.we_n;
    assign stb.be_n = state_ff.be_n;

endmodule : a5bw_strobe_retime

// ===== src/a5bw_ctrl.sv
// Area 5 bus wait controller: control register slave and access sequencer
// Operation
// RQ1: Bits 31..19 of the control register read zero; software writes zero.
// RQ2: Write wait code 000 makes writes use the read wait count.
// RQ3: Write wait codes 001..111 give zero through six wait cycles.
// RQ4: Setup field delays strobes after address by 0.5 to 3.5 cycles.
// RQ5: Read wait code maps to 0-6, 8, 10, 12, 14, 18 or 24 cycles.
// RQ6: Software never writes read wait codes 1101 and above.
// RQ7: Reset sets read wait to 1010, write wait and setup to zero.
// RQ8: Waits count in clocks; half cycles come from opposite-edge strobes.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
module a5bw_ctrl
    import a5bw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic acc_req,
    output logic acc_ready,
    input wire logic acc_write,
    input wire logic [25:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    input wire logic [3:0] acc_be,
    output logic acc_done,
    output logic [31:0] acc_rdata,
    output logic [25:0] ext_addr,
    output logic chip_select_n,
    output logic rd_n,
    output logic we_n,
    output logic [3:0] byte_enable_n,
    input wire logic [31:0] ext_data_in,
    output logic [31:0] ext_data_out,
    output logic ext_data_oe
);

    // ****************************************
    // State record
    // ****************************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        a5bw_fsm_t fsm;
        logic [4:0] cnt;
        logic [31:0] snap;
        logic wr_op;
        logic [25:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic cs_n;
        logic oe;
        logic stb_on;
        logic done;
        logic [31:0] acc_rdata;
    } a5bw_ctrl_t;

    a5bw_ctrl_t state_ff;
    a5bw_ctrl_t nxt_state;

    a5bw_strobe_if stb_if ();

    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] byte_mask;
    logic [31:0] field_mask;

    // ****************************************
    // Bus handshakes
    // ****************************************
    assign s_axi_awready = ~state_ff.aw_got & ~state_ff.bvalid;
    assign s_axi_wready = ~state_ff.w_got & ~state_ff.bvalid;
    assign s_axi_arready = ~state_ff.rvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign aw_have = state_ff.aw_got | aw_take;
    assign w_have = state_ff.w_got | w_take;
    assign wr_addr = state_ff.aw_got ? state_ff.aw_addr : s_axi_awaddr;
    assign wr_data = state_ff.w_got ? state_ff.w_data : s_axi_wdata;
    assign wr_strb = state_ff.w_got ? state_ff.w_strb : s_axi_wstrb;

    // Byte lane mask from the write strobes
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign byte_mask[8*i+7:8*i] = {8{wr_strb[i]}};
    end

    // Only defined fields are writable; reserved bits stay zero
    assign field_mask = byte_mask & A5BW_CTRL_WMASK;  // [RQ1]

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        // Write address and data, in either order
        if (aw_take) begin
            nxt_state.aw_got = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            nxt_state.w_got = 1'b1;
            nxt_state.w_data = s_axi_wdata;
            nxt_state.w_strb = s_axi_wstrb;
        end
        if (aw_have && w_have && !state_ff.bvalid) begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.bvalid = 1'b1;
            if (wr_addr[11:2] == A5BW_CTRL_OFS[11:2]) begin
                nxt_state.ctrl = (state_ff.ctrl & ~field_mask) | (wr_data & field_mask);
                nxt_state.bresp = A5BW_RESP_OKAY;
            end else begin
                nxt_state.bresp = A5BW_RESP_DECERR;
            end
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end
        // Read channel; reserved bits are held zero in the register
        if (s_axi_arvalid && !state_ff.rvalid) begin
            nxt_state.rvalid = 1'b1;
            if (s_axi_araddr[11:2] == A5BW_CTRL_OFS[11:2]) begin
                nxt_state.rdata = state_ff.ctrl;  // [RQ1]
                nxt_state.rresp = A5BW_RESP_OKAY;
            end else begin
                nxt_state.rdata = 32'h0000_0000;
                nxt_state.rresp = A5BW_RESP_DECERR;
            end
        end else if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end
        // External access sequencer
        case (state_ff.fsm)
            A5BW_IDLE: begin
                if (acc_req) begin
                    nxt_state.snap = state_ff.ctrl;
                    nxt_state.wr_op = acc_write;
                    nxt_state.addr = acc_addr;
                    nxt_state.wdata = acc_wdata;
                    nxt_state.be = acc_be;
                    nxt_state.cs_n = 1'b0;
                    nxt_state.oe = acc_write;
                    if (state_ff.ctrl[A5BW_SW_MSB:A5BW_SW_LSB] == 2'h0) begin
                        // Setup 0.5: strobe goes out on the coming falling edge
                        nxt_state.stb_on = 1'b1;  // [RQ4] [RQ8]
                        nxt_state.cnt = a5bw_phase_wait(acc_write, state_ff.ctrl);
                        nxt_state.fsm = A5BW_STROBE;
                    end else begin
                        nxt_state.cnt = {3'h0, state_ff.ctrl[A5BW_SW_MSB:A5BW_SW_LSB]};  // [RQ4]
                        nxt_state.fsm = A5BW_SETUP;
                    end
                end
            end
            A5BW_SETUP: begin
                if (state_ff.cnt == 5'h01) begin
                    nxt_state.stb_on = 1'b1;  // [RQ4]
                    nxt_state.cnt = a5bw_phase_wait(state_ff.wr_op, state_ff.snap);  // [RQ2] [RQ3] [RQ5]
                    nxt_state.fsm = A5BW_STROBE;
                end else begin
                    nxt_state.cnt = state_ff.cnt - 5'h01;  // [RQ8]
                end
            end
            A5BW_STROBE: begin
                if (state_ff.cnt == 5'h00) begin
                    nxt_state.stb_on = 1'b0;
                    if (!state_ff.wr_op) begin
                        nxt_state.acc_rdata = ext_data_in;
                    end
                    nxt_state.fsm = A5BW_HOLD;
                end else begin
                    nxt_state.cnt = state_ff.cnt - 5'h01;  // [RQ8]
                end
            end
            A5BW_HOLD: begin
                // Strobe negated on the falling edge; chip select negated half a cycle later
                nxt_state.cs_n = 1'b1;
                nxt_state.oe = 1'b0;
                nxt_state.done = 1'b1;
                nxt_state.fsm = A5BW_IDLE;
            end
            default: begin
                nxt_state.fsm = A5BW_IDLE;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset image of the state record: idle, chip select off, default timing
    localparam a5bw_ctrl_t CTRL_RST_IMG = '{
        ctrl: A5BW_CTRL_RST,
        fsm: A5BW_IDLE,
        cs_n: 1'b1,
        default: '0
    };

    // Whole state record registered on the rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= CTRL_RST_IMG;  // [RQ7]
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Strobe retimer and outputs
    // ****************************************
    assign stb_if.rd_req = state_ff.stb_on & ~state_ff.wr_op;
    assign stb_if.wr_req = state_ff.stb_on & state_ff.wr_op;
    assign stb_if.be_req = (state_ff.stb_on & state_ff.wr_op) ? state_ff.be : 4'h0;

    a5bw_strobe_retime u_retime (
        .aclk(aclk),
        .aresetn(aresetn),
        .stb(stb_if.retime)
    );

    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;
    assign s_axi_rvalid = state_ff.rvalid;
    assign acc_ready = (state_ff.fsm == A5BW_IDLE);
    assign acc_done = state_ff.done;
    assign acc_rdata = state_ff.acc_rdata;
    assign ext_addr = state_ff.addr;
    assign chip_select_n = state_ff.cs_n;
    assign rd_n = stb_if.rd_n;
    assign we_n = stb_if.we_n;
    assign byte_enable_n = stb_if.be_n;
    assign ext_data_out = state_ff.wdata;
    assign ext_data_oe = state_ff.oe;

    // ****************************************
    // Checks
    // ****************************************
    logic [5:0] slen_ff;
    logic [5:0] pre_ff;

    // Strobe length and setup length counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slen_ff <= 6'h00;
            pre_ff <= 6'h00;
        end else begin
            slen_ff <= state_ff.stb_on ? slen_ff + 6'h01 : 6'h00;
            pre_ff <= (!state_ff.cs_n && !state_ff.stb_on && state_ff.fsm == A5BW_SETUP) ?
                      pre_ff + 6'h01 : 6'h00;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:A5BW_RSV_LSB] == 13'h0000) // [RQ1]
        else $error("Reserved bits read non-zero");
    AST_WW_SAME: assert property ( // [RQ2]
        $fell(state_ff.stb_on) && state_ff.wr_op
        && state_ff.snap[A5BW_WW_MSB:A5BW_WW_LSB] == 3'h0
        |-> slen_ff == {1'b0, a5bw_rd_wait(state_ff.snap[A5BW_RW_MSB:A5BW_RW_LSB])} + 6'h01)
        else $error("Write with code 000 did not follow read wait");
    AST_WW_LIN: assert property ( // [RQ3]
        $fell(state_ff.stb_on) && state_ff.wr_op
        && state_ff.snap[A5BW_WW_MSB:A5BW_WW_LSB] != 3'h0
        |-> slen_ff == {3'h0, state_ff.snap[A5BW_WW_MSB:A5BW_WW_LSB]})
        else $error("Write wait length wrong");
    AST_SETUP: assert property ( // [RQ4]
        $rose(state_ff.stb_on) |-> pre_ff == {4'h0, state_ff.snap[A5BW_SW_MSB:A5BW_SW_LSB]})
        else $error("Setup delay wrong");
    AST_RD_WAIT: assert property ( // [RQ5]
        $fell(state_ff.stb_on) && !state_ff.wr_op
        |-> slen_ff == {1'b0, a5bw_rd_wait(state_ff.snap[A5BW_RW_MSB:A5BW_RW_LSB])} + 6'h01)
        else $error("Read wait length wrong");
    AST_RST_VAL: assert property ($past(aresetn) == 1'b0 |-> state_ff.ctrl == A5BW_CTRL_RST) // [RQ7]
        else $error("Control register reset value wrong");
    AST_HALF: assert property ( // [RQ8]
        $fell(state_ff.stb_on) && !state_ff.wr_op |-> rd_n && !chip_select_n ##1 chip_select_n)
        else $error("Strobe not negated half a cycle before chip select");
    AST_CS_SPAN: assert property ( // [RQ8]
        !rd_n || !we_n |-> !chip_select_n)
        else $error("Chip select dropped during strobe");

    CVR_READ: cover property (acc_done && !state_ff.wr_op);
    CVR_WRITE: cover property (acc_done && state_ff.wr_op);
    CVR_SETUP3: cover property ($rose(state_ff.stb_on) && pre_ff == 6'h03);
    CVR_REGWR: cover property (s_axi_bvalid && s_axi_bresp == A5BW_RESP_OKAY);

endmodule : a5bw_ctrl

// ===== bench/a5bw_sram_model.sv
// Behavioural external SRAM on area 5 with strobe timing capture
`timescale 1ns/1ps
module a5bw_sram_model (
    input wire logic aclk,
    input wire logic [25:0] ext_addr,
    input wire logic chip_select_n,
    input wire logic rd_n,
    input wire logic we_n,
    input wire logic [3:0] byte_enable_n,
    input wire logic [31:0] ext_data_out,
    output logic [31:0] ext_data_in
);
    // ****************************************
    // Storage, data lines and edge times
    // ****************************************
    logic [31:0] mem [0:255];
    logic [31:0] junk;
    realtime t_cs, t_sa, t_sn, t_ce;
    wire logic stb_n = rd_n & we_n;
    // Known contents so that reads can be predicted
    initial begin
        junk = 32'h0f0f_0f0f;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'h5a00_0000 + 32'(i);
        end
    end
    // Released data lines toggle every cycle so stale data never passes
    always @(negedge aclk) begin
        junk <= ~junk;
    end
    assign ext_data_in = (!rd_n && !chip_select_n) ? mem[ext_addr[9:2]] : junk;
    // Write lanes are taken mid-strobe, away from the strobe edges
    always @(posedge aclk) begin
        if (!we_n && !chip_select_n) begin
            for (int b = 0; b < 4; b++) begin
                if (!byte_enable_n[b]) begin
                    mem[ext_addr[9:2]][8*b +: 8] = ext_data_out[8*b +: 8];
                end
            end
        end
    end
    // Edge times give setup, strobe width and hold in nanoseconds
    always @(negedge chip_select_n) t_cs = $realtime;
    always @(negedge stb_n) t_sa = $realtime;
    always @(posedge stb_n) t_sn = $realtime;
    always @(posedge chip_select_n) t_ce = $realtime;
endmodule : a5bw_sram_model

// ===== bench/area5_bus_wait_timing_tb.sv
// Self-checking bench for the area 5 wait controller
`timescale 1ns/1ps
module area5_bus_wait_timing_tb;
    import a5bw_pkg::*;
    // ****************************************
    // Signals, clock, design and partner
    // ****************************************
    localparam int LIMIT = 20000;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, acc_wdata, acc_rdata, ext_data_in, ext_data_out;
    logic [3:0] s_axi_wstrb, acc_be, byte_enable_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic acc_req, acc_ready, acc_write, acc_done, chip_select_n, rd_n, we_n, ext_data_oe;
    logic [25:0] acc_addr, ext_addr;
    logic [31:0] q, e;
    int errors, checks_done, cyc;

    a5bw_ctrl a5bw_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .acc_req(acc_req), .acc_ready(acc_ready),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_be(acc_be),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .ext_addr(ext_addr),
        .chip_select_n(chip_select_n), .rd_n(rd_n), .we_n(we_n), .byte_enable_n(byte_enable_n),
        .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe));

    a5bw_sram_model a5bw_sram_model_inst (.aclk(aclk), .ext_addr(ext_addr),
        .chip_select_n(chip_select_n), .rd_n(rd_n), .we_n(we_n), .byte_enable_n(byte_enable_n),
        .ext_data_out(ext_data_out), .ext_data_in(ext_data_in));

    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Cycle ceiling cuts a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            give_verdict();
        end
    end

    // ****************************************
    // Compare, bus and access tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic chk_t(input string n, input real x, input real g);
        checks_done++;
        if (g < x - 0.01 || g > x + 0.01) begin
            errors++;
            $display("mismatch %s expected %f seen %f", n, x, g);
        end
    endtask : chk_t

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // Writes the control word and expects an OKAY answer
    task automatic cfg(input logic [31:0] v);
        logic [1:0] r;
        axi_write(A5BW_CTRL_OFS, v, r);
        chk("bresp", {30'h0, A5BW_RESP_OKAY}, {30'h0, r});
    endtask : cfg

    // One external access; s is the setup code, w the expected wait cycles
    task automatic acc(input logic wr, input int idx, input logic [31:0] d, input logic [3:0] be,
                       input int s, input int w, output logic [31:0] rd);
        acc_req <= 1'b1;
        acc_write <= wr;
        acc_addr <= 26'(idx * 4);
        acc_wdata <= d;
        acc_be <= be;
        do @(posedge aclk); while (acc_ready !== 1'b1);
        acc_req <= 1'b0;
        @(posedge aclk);
        chk("data_oe in access", {31'h0, wr}, {31'h0, ext_data_oe});
        chk("ext_addr", 32'(idx * 4), {6'h0, ext_addr});
        do @(posedge aclk); while (acc_done !== 1'b1);
        rd = acc_rdata;
        chk("cs_n at done", 32'h1, {31'h0, chip_select_n});
        chk("data_oe at done", 32'h0, {31'h0, ext_data_oe});
        chk_t("setup", (s + 0.5) * 25.0, a5bw_sram_model_inst.t_sa - a5bw_sram_model_inst.t_cs);
        chk_t("width", (w + 1) * 25.0, a5bw_sram_model_inst.t_sn - a5bw_sram_model_inst.t_sa);
        chk_t("hold", 12.5, a5bw_sram_model_inst.t_ce - a5bw_sram_model_inst.t_sn);
    endtask : acc

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {errors, checks_done, cyc} = '0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {acc_req, acc_write, acc_addr, acc_wdata, acc_be} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(A5BW_CTRL_OFS, q, resp);
        chk("reset value", 32'h0000_0500, q);
        axi_read(12'h004, q, resp);
        chk("unmapped rresp", {30'h0, A5BW_RESP_DECERR}, {30'h0, resp});
        chk("unmapped rdata", 32'h0, q);
        axi_write(12'h008, 32'h0000_0080, resp);
        chk("unmapped bresp", {30'h0, A5BW_RESP_DECERR}, {30'h0, resp});
        // Reset timing: 14 waits, 0.5 setup, writes follow reads
        acc(1'b0, 200, 32'h0, 4'hf, 0, 14, q);
        chk("default read", 32'h5a00_00c8, q);
        acc(1'b1, 100, 32'h1234_5678, 4'hf, 0, 14, q);
        chk("default write", 32'h1234_5678, a5bw_sram_model_inst.mem[100]);
        // Reserved bits read zero after a full field write
        cfg(32'h0007_1e00);
        axi_read(A5BW_CTRL_OFS, q, resp);
        chk("field readback", 32'h0007_1e00, q);
        // Only the strobed byte lane is merged into the word
        s_axi_wstrb <= 4'h4;
        cfg(32'h0000_0000);
        s_axi_wstrb <= 4'hf;
        axi_read(A5BW_CTRL_OFS, q, resp);
        chk("lane merge", 32'h0000_1e00, q);
        // Every legal read wait code, the setup code cycling through 0 to 3
        for (int rc = 0; rc <= 12; rc++) begin
            cfg(32'(rc) << 7 | 32'(rc % 4) << 11);
            e = (rc < 7) ? 32'(rc) : (rc < 11) ? 32'(2 * rc - 6) : (rc == 11) ? 32'd18 : 32'd24;
            acc(1'b0, 32 + rc, 32'h0, 4'hf, rc % 4, int'(e), q);
            chk("read data", 32'h5a00_0020 + 32'(rc), q);
        end
        // Every write wait code 001 to 111 against an 18-cycle read wait
        for (int ww = 1; ww <= 7; ww++) begin
            cfg(32'(ww) << 16 | 32'hb << 7 | 32'(ww % 4) << 11);
            e = 32'hc0de_0000 + 32'(ww);
            if (ww == 3) begin
                e = {8'h5a, e[23:8], 8'h03};
            end
            acc(1'b1, ww, 32'hc0de_0000 + 32'(ww), (ww == 3) ? 4'h6 : 4'hf, ww % 4, ww - 1, q);
            chk("written word", e, a5bw_sram_model_inst.mem[ww]);
        end
        // Write wait 000 takes the read wait count of 3
        cfg(32'h3 << 7);
        acc(1'b1, 60, 32'hfeed_beef, 4'hf, 0, 3, q);
        chk("follow write", 32'hfeed_beef, a5bw_sram_model_inst.mem[60]);
        // Reset in mid-run restores the default timing word
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(A5BW_CTRL_OFS, q, resp);
        chk("reset again", 32'h0000_0500, q);
        give_verdict();
    end
endmodule : area5_bus_wait_timing_tb
